// File: src/arsq_pkg.sv
// package: register map, field layout, reset values and timing for the record sequencer
package arsq_pkg;
  // register byte offsets
  localparam logic [7:0] ARSQ_CTRL_OFF = 8'h00;
  localparam logic [7:0] ARSQ_SETUP_OFF = 8'h04;
  localparam logic [7:0] ARSQ_AVG_OFF = 8'h08;
  localparam logic [7:0] ARSQ_CURS_OFF = 8'h0C;
  localparam logic [7:0] ARSQ_EXP_OFF = 8'h10;
  localparam logic [7:0] ARSQ_STAT_OFF = 8'h14;
  localparam logic [7:0] ARSQ_POS_OFF = 8'h18;
  localparam logic [7:0] ARSQ_VIS_OFF = 8'h1C;
  // ctrl register bits (run, stop and geometry run pulse on a one; geometry enable and expansion are stored)
  localparam int ARSQ_CTRL_RUN = 0;
  localparam int ARSQ_CTRL_STOP = 1;
  localparam int ARSQ_CTRL_GEOM_RUN = 2;
  localparam int ARSQ_CTRL_GEOM_EN = 3;
  localparam int ARSQ_CTRL_XPAND = 4;
  // setup register fields
  localparam int ARSQ_MODE_LSB = 0;
  localparam int ARSQ_HOLD_BIT = 2;
  localparam int ARSQ_LEN_LSB = 4;
  localparam int ARSQ_TW_LSB = 8;
  localparam int ARSQ_START_LSB = 12;
  localparam int ARSQ_NREC_LSB = 16;
  // modes
  typedef enum logic [1:0] {
    ARSQ_MODE_SINGLE = 2'b00,
    ARSQ_MODE_ADVANCE = 2'b01,
    ARSQ_MODE_AVERAGE = 2'b10
  } arsq_mode_t;
  // record length codes
  localparam logic [1:0] ARSQ_LEN_256 = 2'h0;
  localparam logic [1:0] ARSQ_LEN_512 = 2'h1;
  localparam logic [1:0] ARSQ_LEN_1024 = 2'h2;
  // capture duration codes 0..13 = 5 ns .. 100 us in 1-2-5 steps
  localparam logic [3:0] ARSQ_TW_MAX = 4'hD;
  localparam logic [3:0] ARSQ_TW_RESET = 4'h7;
  localparam logic [3:0] ARSQ_REC_MAX = 4'hF;
  localparam logic [3:0] ARSQ_NVOL_LAST = 4'h3;
  localparam logic [10:0] ARSQ_AVG_MIN = 11'h001;
  localparam logic [10:0] ARSQ_AVG_MAX = 11'h400;
  localparam logic [10:0] ARSQ_AVG_RESET = 11'h010;
  localparam logic [10:0] ARSQ_POS_RESET = 11'h001;
  localparam logic [3:0] ARSQ_GEOM_PASSES = 4'h8;
  // display refresh period while averaging
  localparam longint ARSQ_CLK_HZ = 50000000;
  localparam longint ARSQ_REFRESH_S = 5;
  localparam int ARSQ_REFRESH_CYC = int'(ARSQ_CLK_HZ * ARSQ_REFRESH_S);
  localparam logic [1:0] ARSQ_RESP_OK = 2'b00;
  localparam logic [1:0] ARSQ_RESP_SLVERR = 2'b10;
endpackage : arsq_pkg

// File: src/arsq_rec_mem.sv
`timescale 1ns/1ps
// record status memory: one word per record, registered read port
module arsq_rec_mem
  import arsq_pkg::*;
(
  input wire logic aclk,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [3:0] raddr,
  output logic [15:0] rdata
);
  logic [15:0] mem [0:15];

  // no reset: content models record storage that outlives the sequencer
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : arsq_rec_mem

// File: src/arsq_clamp.sv
`timescale 1ns/1ps
// position clamp: keeps a cursor or expansion point within 1..record length
module arsq_clamp
  import arsq_pkg::*;
(
  input wire logic [10:0] pos_in,
  input wire logic [1:0] len_code,
  output logic [10:0] pos_out
);
  logic [10:0] lim;

  always_comb begin
    case (len_code)
      ARSQ_LEN_256: lim = 11'h100;
      ARSQ_LEN_1024: lim = 11'h400;
      default: lim = 11'h200;
    endcase
    if (pos_in < ARSQ_POS_RESET) begin
      pos_out = ARSQ_POS_RESET;
    end else if (pos_in > lim) begin
      pos_out = lim;
    end else begin
      pos_out = pos_in;
    end
  end
endmodule : arsq_clamp

// File: src/arsq_top.sv
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
// acquisition record sequencer with AXI4-Lite register access
// Behaviour
// - three modes, single-record after reset
// - single, no hold: refill start record repeatedly
// - single with hold: fill once, halt
// - advance fills successive records from start
// - index past sixteen wraps to one
// - advance without hold cycles until stopped
// - advance with hold fills each once, halts
// - average count 1..1024, default 16
// - refresh display every five seconds averaging
// - curve query held until average completes
// - setting change restarts running average
// - duration 5 ns..100 us, default 1 us
// - length 256/512/1024, default 512
// - display mapping chosen by record length
// - twofold expansion only with 1024 samples
// - clamp cursor and expansion after length change
// - start record 1..16, default 1
// - records one to four are non-volatile
// - record count/average count visible per mode
// - geometry map run; correction when enabled
// - record count 1..16, default 1
// - hold done ignores triggers until restart
module arsq_top
  import arsq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic trig_in,
  input wire logic acq_done_in,
  input wire logic curve_query,
  output logic curve_grant,
  output logic arm_out,
  output logic [3:0] rec_index,
  output logic rec_nonvolatile,
  output logic [3:0] capture_duration,
  output logic [1:0] pix_map,
  output logic display_refresh,
  output logic geom_acq,
  output logic geom_correct
);
  typedef enum logic [1:0] {
    ARSQ_ST_IDLE = 2'b00,
    ARSQ_ST_ARMED = 2'b01,
    ARSQ_ST_FILL = 2'b10,
    ARSQ_ST_GEOM = 2'b11
  } arsq_state_t;

  arsq_state_t state_reg;
  logic [1:0] mode_reg;
  logic stop_after_fill;
  logic [1:0] len_reg;
  logic [3:0] tw_reg;
  logic [3:0] start_reg;
  logic [3:0] nrec_reg;
  logic [10:0] navg_reg;
  logic [10:0] curs_reg;
  logic [10:0] exp_reg;
  logic xpand_reg;
  logic geom_en_reg;
  logic [3:0] idx_reg;
  logic [4:0] filled_reg;
  logic [10:0] avg_done_reg;
  logic [3:0] geom_cnt_reg;
  logic [31:0] refresh_cnt_reg;
  logic trig_s1, trig_s2, trig_s3, trig_prev;
  logic done_s1, done_s2, done_s3, done_prev;
  logic trig_ev, done_ev;
  logic aw_held, w_held;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go, setup_wr, ctrl_wr;
  logic run_pulse, stop_pulse, geom_pulse;
  logic len_change;
  logic [10:0] curs_clamped, exp_clamped;
  logic [15:0] mem_rdata;
  logic [31:0] rd_word;

  // decoding shared by the write response and the read response
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a[1:0] == 2'b00) && (a <= ARSQ_VIS_OFF);
  endfunction : addr_mapped

  // pins are asynchronous: three stages, edge counted when stage 2 and 3 agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {trig_s1, trig_s2, trig_s3, trig_prev} <= 4'h0;
      {done_s1, done_s2, done_s3, done_prev} <= 4'h0;
    end else begin
      trig_s1 <= trig_in;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
      if (trig_s2 == trig_s3) begin
        trig_prev <= trig_s3;
      end
      done_s1 <= acq_done_in;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      if (done_s2 == done_s3) begin
        done_prev <= done_s3;
      end
    end
  end
  assign trig_ev = (trig_s2 == trig_s3) && trig_s3 && !trig_prev;
  assign done_ev = (done_s2 == done_s3) && done_s3 && !done_prev;

  // write channels may arrive in either order; hold each until both are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ARSQ_RESP_OK;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(awaddr_reg) ? ARSQ_RESP_OK : ARSQ_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign setup_wr = wr_go && (awaddr_reg == ARSQ_SETUP_OFF);
  assign ctrl_wr = wr_go && (awaddr_reg == ARSQ_CTRL_OFF) && wstrb_reg[0];
  assign run_pulse = ctrl_wr && wdata_reg[ARSQ_CTRL_RUN];
  assign stop_pulse = ctrl_wr && wdata_reg[ARSQ_CTRL_STOP];
  assign geom_pulse = ctrl_wr && wdata_reg[ARSQ_CTRL_GEOM_RUN];

  // setup fields; out-of-range values are refused and the old value kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg <= ARSQ_MODE_SINGLE;
      stop_after_fill <= 1'b0;
      len_reg <= ARSQ_LEN_512;
      tw_reg <= ARSQ_TW_RESET;
      start_reg <= 4'h0;
      nrec_reg <= 4'h0;
    end else if (setup_wr) begin
      if (wstrb_reg[0]) begin
        if (wdata_reg[ARSQ_MODE_LSB +: 2] != 2'b11) begin
          mode_reg <= wdata_reg[ARSQ_MODE_LSB +: 2];
        end
        stop_after_fill <= wdata_reg[ARSQ_HOLD_BIT];
        if (wdata_reg[ARSQ_LEN_LSB +: 2] != 2'b11) begin
          len_reg <= wdata_reg[ARSQ_LEN_LSB +: 2];
        end
      end
      if (wstrb_reg[1]) begin
        if (wdata_reg[ARSQ_TW_LSB +: 4] <= ARSQ_TW_MAX) begin
          tw_reg <= wdata_reg[ARSQ_TW_LSB +: 4];
        end
        start_reg <= wdata_reg[ARSQ_START_LSB +: 4]; // stored as record minus one
      end
      if (wstrb_reg[2]) begin
        nrec_reg <= wdata_reg[ARSQ_NREC_LSB +: 4]; // stored as count minus one
      end
    end
  end

  // average count, cursor and expansion point; length change clamps positions
  assign len_change = setup_wr && wstrb_reg[0] && (wdata_reg[ARSQ_LEN_LSB +: 2] != 2'b11)
                      && (wdata_reg[ARSQ_LEN_LSB +: 2] != len_reg);
  arsq_clamp u_curs_clamp (
    .pos_in(curs_reg),
    .len_code(wdata_reg[ARSQ_LEN_LSB +: 2]),
    .pos_out(curs_clamped)
  );
  arsq_clamp u_exp_clamp (
    .pos_in(exp_reg),
    .len_code(wdata_reg[ARSQ_LEN_LSB +: 2]),
    .pos_out(exp_clamped)
  );
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      navg_reg <= ARSQ_AVG_RESET;
      curs_reg <= ARSQ_POS_RESET;
      exp_reg <= ARSQ_POS_RESET;
      xpand_reg <= 1'b0;
      geom_en_reg <= 1'b0;
    end else begin
      if (wr_go && awaddr_reg == ARSQ_AVG_OFF && wstrb_reg[0]
          && wdata_reg[10:0] >= ARSQ_AVG_MIN && wdata_reg[10:0] <= ARSQ_AVG_MAX) begin
        navg_reg <= wdata_reg[10:0];
      end
      if (len_change) begin
        curs_reg <= curs_clamped;
        exp_reg <= exp_clamped;
      end else begin
        if (wr_go && awaddr_reg == ARSQ_CURS_OFF) begin
          curs_reg <= wdata_reg[10:0];
        end
        if (wr_go && awaddr_reg == ARSQ_EXP_OFF) begin
          exp_reg <= wdata_reg[10:0];
        end
      end
      if (ctrl_wr) begin
        xpand_reg <= wdata_reg[ARSQ_CTRL_XPAND];
        geom_en_reg <= wdata_reg[ARSQ_CTRL_GEOM_EN];
      end
    end
  end

  // acquisition sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ARSQ_ST_IDLE;
      idx_reg <= 4'h0;
      filled_reg <= 5'h00;
      avg_done_reg <= 11'h000;
      geom_cnt_reg <= 4'h0;
    end else begin
      case (state_reg)
        ARSQ_ST_IDLE: begin
          if (geom_pulse) begin
            state_reg <= ARSQ_ST_GEOM;
            geom_cnt_reg <= 4'h0;
          end else if (run_pulse) begin
            state_reg <= ARSQ_ST_ARMED;
            idx_reg <= start_reg;
            filled_reg <= 5'h00;
            avg_done_reg <= 11'h000;
          end
        end
        ARSQ_ST_ARMED: begin
          if (stop_pulse) begin
            state_reg <= ARSQ_ST_IDLE;
          end else if (setup_wr && mode_reg == ARSQ_MODE_AVERAGE) begin
            avg_done_reg <= 11'h000;
          end else if (trig_ev) begin
            state_reg <= ARSQ_ST_FILL;
          end
        end
        ARSQ_ST_FILL: begin
          if (stop_pulse) begin
            state_reg <= ARSQ_ST_IDLE;
          end else if (setup_wr && mode_reg == ARSQ_MODE_AVERAGE) begin
            avg_done_reg <= 11'h000;
            state_reg <= ARSQ_ST_ARMED;
          end else if (done_ev) begin
            state_reg <= ARSQ_ST_ARMED;
            case (mode_reg)
              ARSQ_MODE_ADVANCE: begin
                idx_reg <= idx_reg + 4'h1; // 4-bit wrap sends 16 to 1
                if (filled_reg[3:0] == nrec_reg) begin
                  filled_reg <= 5'h00;
                  idx_reg <= start_reg;
                  if (stop_after_fill) begin
                    state_reg <= ARSQ_ST_IDLE;
                  end
                end else begin
                  filled_reg <= filled_reg + 5'h01;
                end
              end
              ARSQ_MODE_AVERAGE: begin
                if (avg_done_reg + 11'h001 >= navg_reg) begin
                  avg_done_reg <= navg_reg;
                  state_reg <= ARSQ_ST_IDLE;
                end else begin
                  avg_done_reg <= avg_done_reg + 11'h001;
                end
              end
              default: begin
                if (stop_after_fill) begin
                  state_reg <= ARSQ_ST_IDLE;
                end // else refill same record
              end
            endcase
          end
        end
        ARSQ_ST_GEOM: begin
          if (stop_pulse || geom_cnt_reg == ARSQ_GEOM_PASSES) begin
            state_reg <= ARSQ_ST_IDLE;
          end else if (done_ev) begin
            geom_cnt_reg <= geom_cnt_reg + 4'h1;
          end
        end
        default: state_reg <= ARSQ_ST_IDLE;
      endcase
    end
  end

  // five second refresh strobe while averaging
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      refresh_cnt_reg <= 32'h0000_0000;
      display_refresh <= 1'b0;
    end else if (state_reg != ARSQ_ST_IDLE && mode_reg == ARSQ_MODE_AVERAGE) begin
      display_refresh <= (refresh_cnt_reg == 32'(ARSQ_REFRESH_CYC - 1));
      if (refresh_cnt_reg == 32'(ARSQ_REFRESH_CYC - 1)) begin
        refresh_cnt_reg <= 32'h0000_0000;
      end else begin
        refresh_cnt_reg <= refresh_cnt_reg + 32'h0000_0001;
      end
    end else begin
      refresh_cnt_reg <= 32'h0000_0000;
      display_refresh <= 1'b0;
    end
  end

  // record memory logs the capture duration code of each filled record
  arsq_rec_mem u_mem (
    .aclk(aclk),
    .we(done_ev && state_reg == ARSQ_ST_FILL),
    .waddr(idx_reg),
    .wdata({12'h000, tw_reg}),
    .raddr(s_axi_araddr[5:2]),
    .rdata(mem_rdata)
  );

  // outputs to the acquisition front end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arm_out <= 1'b0;
      rec_index <= 4'h0;
      rec_nonvolatile <= 1'b0;
      capture_duration <= ARSQ_TW_RESET;
      pix_map <= ARSQ_LEN_512;
      geom_acq <= 1'b0;
      geom_correct <= 1'b0;
      curve_grant <= 1'b0;
    end else begin
      arm_out <= (state_reg == ARSQ_ST_ARMED); // no arm once halted
      rec_index <= idx_reg;
      rec_nonvolatile <= (idx_reg <= ARSQ_NVOL_LAST);
      capture_duration <= tw_reg;
      pix_map <= len_reg; // 0 every other pixel, 1 one-to-one, 2 min-max pair
      geom_acq <= (state_reg == ARSQ_ST_GEOM);
      geom_correct <= geom_en_reg;
      curve_grant <= curve_query && !(mode_reg == ARSQ_MODE_AVERAGE
                     && state_reg != ARSQ_ST_IDLE);
    end
  end

  // read mux
  always_comb begin
    rd_word = 32'h0000_0000;
    case (s_axi_araddr)
      ARSQ_SETUP_OFF: rd_word = {12'h000, nrec_reg, start_reg, tw_reg, 2'b00, len_reg,
                                 1'b0, stop_after_fill, mode_reg};
      ARSQ_AVG_OFF: rd_word = {21'h000000, navg_reg};
      ARSQ_CURS_OFF: rd_word = {21'h000000, curs_reg};
      ARSQ_EXP_OFF: rd_word = {21'h000000, exp_reg};
      ARSQ_STAT_OFF: rd_word = {10'h000, avg_done_reg, filled_reg, geom_cnt_reg, state_reg};
      ARSQ_POS_OFF: rd_word = {23'h000000, xpand_reg && (len_reg == ARSQ_LEN_1024),
                               idx_reg, 3'h0, geom_en_reg};
      ARSQ_VIS_OFF: rd_word = {30'h00000000, mode_reg == ARSQ_MODE_AVERAGE,
                               mode_reg == ARSQ_MODE_ADVANCE};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read channel: data one cycle after address, held until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ARSQ_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? ARSQ_RESP_OK : ARSQ_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
  assign s_axi_arready = !s_axi_rvalid;

  hold_halt_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ARSQ_ST_FILL && done_ev && stop_after_fill && mode_reg == ARSQ_MODE_SINGLE
     && !stop_pulse) |=> state_reg == ARSQ_ST_IDLE)
    else $error("single hold did not halt");
  wrap_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ARSQ_ST_FILL && done_ev && mode_reg == ARSQ_MODE_ADVANCE && !stop_pulse
     && !setup_wr && idx_reg == 4'hF && filled_reg[3:0] != nrec_reg) |=> idx_reg == 4'h0)
    else $error("record index did not wrap");
  avg_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    navg_reg >= ARSQ_AVG_MIN && navg_reg <= ARSQ_AVG_MAX)
    else $error("average count out of range");
  curve_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (mode_reg == ARSQ_MODE_AVERAGE && state_reg == ARSQ_ST_FILL) |=> !curve_grant)
    else $error("curve answered mid average");
  clamp_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
    len_change |=> curs_reg >= ARSQ_POS_RESET && exp_reg >= ARSQ_POS_RESET)
    else $error("position not clamped");
  // skip the edge after reset release: the flag still holds its reset value there
  nvol_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(aresetn) |-> rec_nonvolatile == ($past(idx_reg) <= ARSQ_NVOL_LAST))
    else $error("non-volatile flag wrong");
  halt_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_reg == ARSQ_ST_IDLE && !run_pulse && !geom_pulse) |=> state_reg == ARSQ_ST_IDLE)
    else $error("trigger accepted while halted");
  tw_range_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tw_reg <= ARSQ_TW_MAX)
    else $error("duration code out of range");
  refresh_avg_a: assert property (@(posedge aclk) disable iff (!aresetn)
    display_refresh |-> $past(mode_reg) == ARSQ_MODE_AVERAGE && $past(state_reg) != ARSQ_ST_IDLE)
    else $error("refresh outside averaging");
endmodule : arsq_top

// File: verification/arsq_front_model.sv
// front-end stand-in: one trigger pulse then one record-done pulse per shot
`timescale 1ns/1ps
module arsq_front_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire logic slow,
  output logic trig_in,
  output logic acq_done_in,
  output logic busy
);
  int cnt;
  int dly;
  // shot sequencer; the pause before done is prompt or slow as the bench asks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      dly <= 0;
    end else if (cnt == 0) begin
      cnt <= fire ? 1 : 0;
      dly <= slow ? 40 : 3;
    end else begin
      cnt <= (cnt > dly + 12) ? 0 : cnt + 1;
    end
  end
  // pulses last several cycles so a three-stage synchroniser sees both edges
  assign trig_in = (cnt >= 1) && (cnt <= 4);
  assign acq_done_in = (cnt >= dly + 5) && (cnt <= dly + 9);
  assign busy = cnt != 0;
endmodule : arsq_front_model

// File: verification/tb_top.sv
// self-checking bench for the acquisition record sequencer
`timescale 1ns/1ps
module tb_top;
  import arsq_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] d;
    logic [1:0] r;
  } arsq_row_t;
  localparam int BV = 0, AR = 1, RV = 2, ARM = 3, IDLE = 4;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'h0;
  logic wvalid = 1'h0;
  logic arvalid = 1'h0;
  logic curve_query = 1'h0;
  logic fire = 1'h0;
  logic slow = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, trig_in, acq_done_in, busy;
  logic curve_grant, arm_out, rec_nonvolatile, display_refresh, geom_acq, geom_correct;
  logic [1:0] bresp, rresp, pix_map, sb, sr;
  logic [3:0] rec_index, capture_duration;
  logic [31:0] rdata, sd;
  logic [4:0] fl;
  int errors = 0;
  int checked = 0;
  // reset contents: address, read data, response
  arsq_row_t rows [10] = '{'{ARSQ_CTRL_OFF, 32'h0, ARSQ_RESP_OK},
    '{ARSQ_SETUP_OFF, 32'h710, ARSQ_RESP_OK}, '{ARSQ_AVG_OFF, 32'h10, ARSQ_RESP_OK},
    '{ARSQ_CURS_OFF, 32'h1, ARSQ_RESP_OK}, '{ARSQ_EXP_OFF, 32'h1, ARSQ_RESP_OK},
    '{ARSQ_STAT_OFF, 32'h0, ARSQ_RESP_OK}, '{ARSQ_POS_OFF, 32'h0, ARSQ_RESP_OK},
    '{ARSQ_VIS_OFF, 32'h0, ARSQ_RESP_OK}, '{8'h20, 32'h0, ARSQ_RESP_SLVERR},
    '{8'h02, 32'h0, ARSQ_RESP_SLVERR}};
  // the response channels are always accepted, so their ready lines stay high
  arsq_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .trig_in(trig_in), .acq_done_in(acq_done_in), .curve_query(curve_query),
    .curve_grant(curve_grant), .arm_out(arm_out), .rec_index(rec_index),
    .rec_nonvolatile(rec_nonvolatile), .capture_duration(capture_duration),
    .pix_map(pix_map), .display_refresh(display_refresh), .geom_acq(geom_acq),
    .geom_correct(geom_correct));
  arsq_front_model front_u (.aclk(aclk), .aresetn(aresetn), .fire(fire), .slow(slow),
    .trig_in(trig_in), .acq_done_in(acq_done_in), .busy(busy));
  assign fl = {~busy, arm_out, rvalid, arready & arvalid, bvalid};
  // 50 MHz clock
  initial begin
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // a hang counts as a mismatch
  task automatic tmo;
    errors++;
    final_report();
  endtask : tmo
  // wait for flag k at a rising edge, keeping the answer fields seen before it
  task automatic seen(input int k);
    int n;
    logic t;
    n = 0;
    do begin
      @(negedge aclk);
      t = fl[k];
      sd = rdata;
      sr = rresp;
      sb = bresp;
      @(posedge aclk);
      n++;
      if (n > 99) tmo();
    end while (!t);
  endtask : seen
  // address and data offered together, each released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic ta, tw;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    do begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      n++;
      if (n > 99) tmo();
    end while ((awvalid & ~ta) | (wvalid & ~tw));
    seen(BV);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    seen(AR);
    arvalid <= 1'h0;
    seen(RV);
  endtask : rd
  // one trigger plus one record-done; six edges let the synchronised edge land
  task automatic shot(input logic s);
    slow <= s;
    fire <= 1'h1;
    @(posedge aclk);
    fire <= 1'h0;
    seen(IDLE);
    repeat (6) @(posedge aclk);
  endtask : shot
  function automatic logic [31:0] su(input int m, h, l, t, s, r);
    return 32'((m << ARSQ_MODE_LSB) | (h << ARSQ_HOLD_BIT) | (l << ARSQ_LEN_LSB)
      | (t << ARSQ_TW_LSB) | (s << ARSQ_START_LSB) | (r << ARSQ_NREC_LSB));
  endfunction : su
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk(capture_duration, ARSQ_TW_RESET);
    chk(pix_map, ARSQ_LEN_512);
    chk(arm_out, 0);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(sr, rows[i].r);
      if (rows[i].r === ARSQ_RESP_OK) chk(sd, rows[i].d);
    end
    wr(8'h24, 32'h0);
    chk(sb, ARSQ_RESP_SLVERR);
    // single record, stop after fill, record 3; a later trigger is ignored
    wr(ARSQ_SETUP_OFF, su(0, 1, 1, 7, 2, 0));
    wr(ARSQ_CTRL_OFF, 32'h1);
    seen(ARM);
    chk(rec_index, 2);
    shot(0);
    chk(arm_out, 0);
    shot(1);
    chk(rec_index, 2);
    // single record repeating until stopped
    wr(ARSQ_SETUP_OFF, su(0, 0, 1, 7, 2, 0));
    wr(ARSQ_CTRL_OFF, 32'h1);
    shot(1);
    shot(0);
    chk({arm_out, rec_index}, 5'h12);
    wr(ARSQ_CTRL_OFF, 32'h2);
    repeat (2) @(posedge aclk);
    chk(arm_out, 0);
    // advance from record 16 over three records, wrapping to record 1
    wr(ARSQ_SETUP_OFF, su(1, 1, 1, 7, 15, 2));
    rd(ARSQ_VIS_OFF);
    chk(sd[1:0], 2'h1);
    wr(ARSQ_CTRL_OFF, 32'h1);
    seen(ARM);
    chk({rec_nonvolatile, rec_index}, 5'h0F);
    shot(0);
    chk({rec_nonvolatile, rec_index}, 5'h10);
    shot(1);
    chk({arm_out, rec_index}, 5'h11);
    shot(0);
    chk(arm_out, 0);
    shot(0);
    rd(ARSQ_STAT_OFF);
    chk(sd[1:0], 2'h0);
    // advance over two records without stopping keeps cycling
    wr(ARSQ_SETUP_OFF, su(1, 0, 1, 7, 0, 1));
    wr(ARSQ_CTRL_OFF, 32'h1);
    repeat (3) shot(0);
    chk({arm_out, rec_index}, 5'h11);
    wr(ARSQ_CTRL_OFF, 32'h2);
    // averaging twice; a settings write restarts it; curve answer waits for the end
    wr(ARSQ_SETUP_OFF, su(2, 0, 1, 7, 0, 0));
    wr(ARSQ_AVG_OFF, 32'h401);
    wr(ARSQ_AVG_OFF, 32'h2);
    rd(ARSQ_AVG_OFF);
    chk(sd, 32'h2);
    rd(ARSQ_VIS_OFF);
    chk(sd[1:0], 2'h2);
    curve_query <= 1'h1;
    wr(ARSQ_CTRL_OFF, 32'h1);
    shot(0);
    chk(curve_grant, 0);
    chk(display_refresh, 0);
    wr(ARSQ_SETUP_OFF, su(2, 0, 1, 7, 0, 0));
    rd(ARSQ_STAT_OFF);
    chk(sd[21:11], 11'h0);
    shot(0);
    chk(curve_grant, 0);
    shot(1);
    chk({curve_grant, arm_out}, 2'h2);
    // long records allow expansion; shortening clamps the positions
    wr(ARSQ_SETUP_OFF, su(0, 0, 2, 13, 0, 0));
    // outputs follow the register one edge later; look once they have settled
    @(posedge aclk);
    chk({pix_map, capture_duration}, 6'h2D);
    wr(ARSQ_CURS_OFF, 32'h3E8);
    wr(ARSQ_EXP_OFF, 32'h400);
    wr(ARSQ_CTRL_OFF, 32'h10);
    rd(ARSQ_POS_OFF);
    chk(sd[8], 1);
    wr(ARSQ_SETUP_OFF, su(0, 0, 0, 14, 0, 0));
    @(posedge aclk);
    chk({pix_map, capture_duration}, 6'h0D);
    rd(ARSQ_CURS_OFF);
    chk(sd, 32'h100);
    rd(ARSQ_EXP_OFF);
    chk(sd, 32'h100);
    rd(ARSQ_POS_OFF);
    chk(sd[8], 0);
    // geometry map run lasts its pass count with correction enabled
    wr(ARSQ_CTRL_OFF, 32'hC);
    @(posedge aclk);
    for (int i = 0; i < ARSQ_GEOM_PASSES; i++) begin
      chk({geom_acq, geom_correct}, 2'h3);
      shot(1'(i));
    end
    chk({geom_acq, geom_correct}, 2'h1);
    // second reset after the geometry run restores defaults
    aresetn <= 1'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk({geom_correct, capture_duration}, 5'h07);
    final_report();
  end
endmodule : tb_top
